//--- sbd_defines.svh
// Constants for the subtractive bridge decode link
`ifndef SBD_DEFINES_SVH
`define SBD_DEFINES_SVH
`define SBD_ADDR_W 32
`define SBD_TAG_W 5
`define SBD_FLUSH_CNT_W 4
`define SBD_NUM_RANGES 2
`define SBD_CFG_BUS0 8'h00
`endif

//--- sbd_pkg.sv
// Types shared by both ends of the subtractive bridge link
package sbd_pkg;
    typedef enum logic [1:0] {
        SBD_CMD_NP_READ = 2'b00,
        SBD_CMD_POSTED_WRITE = 2'b01,
        SBD_CMD_FLUSH = 2'b10,
        SBD_CMD_CONFIG = 2'b11
    } sbd_cmd_e;
endpackage

//--- sbd_link_if.sv
// Link between the chain host and the subtractive bridge
`timescale 1ns/1ps
`include "sbd_defines.svh"
interface sbd_link_if;
    // Downstream requests, host to bridge
    logic dn_valid;
    logic dn_ready;
    sbd_pkg::sbd_cmd_e dn_cmd;
    logic [`SBD_ADDR_W-1:0] dn_addr;
    logic dn_legacy_route;
    logic [7:0] dn_bus;
    logic [`SBD_TAG_W-1:0] dn_node_tag;
    // Upstream requests, bridge to host
    logic up_valid;
    logic up_ready;
    sbd_pkg::sbd_cmd_e up_cmd;
    logic [`SBD_ADDR_W-1:0] up_addr;
    // Flush responses, host to bridge
    logic flush_done;
    modport bridge (input dn_valid, output dn_ready, input dn_cmd, input dn_addr, input dn_legacy_route,
        input dn_bus, input dn_node_tag, output up_valid, input up_ready, output up_cmd, output up_addr,
        input flush_done);
    modport host (output dn_valid, input dn_ready, output dn_cmd, output dn_addr, output dn_legacy_route,
        output dn_bus, output dn_node_tag, input up_valid, output up_ready, input up_cmd, input up_addr,
        output flush_done);
endinterface

//--- sbd_host.sv
// Host end: positive range decode, legacy-route flag, flush responder
`timescale 1ns/1ps
`include "sbd_defines.svh"
module sbd_host #(
    parameter int NUM_RANGES = `SBD_NUM_RANGES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Positive decode ranges, one per device or bridge of the chains
    input wire logic [NUM_RANGES*`SBD_ADDR_W-1:0] RANGE_BASE,
    input wire logic [NUM_RANGES*`SBD_ADDR_W-1:0] RANGE_LIMIT,
    input wire logic [NUM_RANGES-1:0] RANGE_ON_COMPAT,
    // Processor-side request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire sbd_pkg::sbd_cmd_e REQ_CMD,
    input wire logic [`SBD_ADDR_W-1:0] REQ_ADDR,
    input wire logic [7:0] REQ_BUS,
    output logic REQ_OTHER_CHAIN,
    // Writes are visible to all processors
    input wire logic WRITES_VISIBLE,
    // Upstream arrivals
    output logic UP_SEEN,
    output logic [`SBD_ADDR_W-1:0] UP_ADDR_OUT,
    // Link
    sbd_link_if.host link
);
    logic [NUM_RANGES-1:0] hit;
    logic any_hit;
    logic compat_hit;
    logic flush_pend_reg;
    logic flush_pend_next;
    logic done_reg;
    logic done_next;
    logic up_seen_reg;
    logic up_seen_next;
    logic [`SBD_ADDR_W-1:0] up_addr_reg;
    logic [`SBD_ADDR_W-1:0] up_addr_next;

    ////////////////////////////////////////////////////////////////////////
    // Range compare per window (see RULE4, see RULE9)
    genvar g;
    generate
        for (g = 0; g < NUM_RANGES; g++) begin : g_rng
            assign hit[g] = REQ_ADDR >= RANGE_BASE[g*`SBD_ADDR_W +: `SBD_ADDR_W] &&
                REQ_ADDR <= RANGE_LIMIT[g*`SBD_ADDR_W +: `SBD_ADDR_W];
        end
    endgenerate
    assign any_hit = |hit;
    assign compat_hit = |(hit & RANGE_ON_COMPAT);

    // Misses go to the compat chain flagged; compat-chain hits go unflagged
    assign link.dn_valid = REQ_VALID && (compat_hit || !any_hit);
    assign link.dn_cmd = REQ_CMD;
    assign link.dn_addr = REQ_ADDR;
    assign link.dn_legacy_route = !any_hit; // see RULE5, see RULE7
    assign link.dn_bus = REQ_BUS;
    assign link.dn_node_tag = '0;
    assign REQ_OTHER_CHAIN = REQ_VALID && any_hit && !compat_hit;
    assign REQ_READY = link.dn_ready || REQ_OTHER_CHAIN;
    assign link.up_ready = !flush_pend_reg;
    assign UP_SEEN = up_seen_reg;
    assign UP_ADDR_OUT = up_addr_reg;
    assign link.flush_done = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // Flush answered only when prior writes are visible (see RULE2)
    always_comb begin
        flush_pend_next = flush_pend_reg;
        done_next = 1'b0;
        if (flush_pend_reg && WRITES_VISIBLE) begin
            flush_pend_next = 1'b0;
            done_next = 1'b1;
        end else if (link.up_valid && link.up_ready && link.up_cmd == sbd_pkg::SBD_CMD_FLUSH) begin
            flush_pend_next = 1'b1;
        end
    end

    // Record each upstream arrival for the processor side
    always_comb begin
        up_seen_next = link.up_valid && link.up_ready;
        up_addr_next = up_addr_reg;
        if (up_seen_next) begin
            up_addr_next = link.up_addr;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flush_pend_reg <= 1'b0;
            done_reg <= 1'b0;
            up_seen_reg <= 1'b0;
            up_addr_reg <= '0;
        end else begin
            flush_pend_reg <= flush_pend_next;
            done_reg <= done_next;
            up_seen_reg <= up_seen_next;
            up_addr_reg <= up_addr_next;
        end
    end
endmodule

//--- sbd_bridge.sv
// Bridge end: subtractive claim, secondary forwarding, flush tracking
// Functional notes
// RULE1 - Flush request after each legacy posted write
// RULE2 - Host answers flush once write visible
// RULE3 - Visibility pin asserted only with none outstanding
// RULE4 - Host ranges cover all chain devices
// RULE5 - Host flags misses toward compat chain
// RULE6 - Flagged primary requests claimed regardless of address
// RULE7 - Unflagged requests claimed by positive decode
// RULE8 - Flagged claim works with zero node tag
// RULE9 - Function-header host keeps own range registers
// RULE10 - Chain-end bridge may accept everything
// RULE11 - Bridge header: forward secondary misses upstream
// RULE12 - Function header: claim all secondary transactions
// RULE13 - Function header: primary appears on bus 0
// RULE14 - Outstanding flush counter, pin when zero
`timescale 1ns/1ps
`include "sbd_defines.svh"
module sbd_bridge #(
    parameter int CNT_W = `SBD_FLUSH_CNT_W
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Straps
    input wire logic CHAIN_END,
    input wire logic FUNC_HEADER,
    // Bridge-header window and own positive range
    input wire logic [`SBD_ADDR_W-1:0] WIN_BASE,
    input wire logic [`SBD_ADDR_W-1:0] WIN_LIMIT,
    // Claimed primary request toward the legacy bus
    output logic CLAIM_VALID,
    output sbd_pkg::sbd_cmd_e CLAIM_CMD,
    output logic [`SBD_ADDR_W-1:0] CLAIM_ADDR,
    // Secondary-side request from the legacy bus
    input wire logic SEC_VALID,
    output logic SEC_READY,
    input wire sbd_pkg::sbd_cmd_e SEC_CMD,
    input wire logic [`SBD_ADDR_W-1:0] SEC_ADDR,
    input wire logic SEC_FROM_LEGACY,
    output logic SEC_LOCAL,
    // Write-visibility pin, active low
    output logic POSTED_WRITE_VISIBLE_N,
    // Link
    sbd_link_if.bridge link
);
    typedef enum logic [1:0] {
        SBD_UP_IDLE = 2'b00,
        SBD_UP_REQ = 2'b01,
        SBD_UP_FLUSH = 2'b10
    } sbd_up_e;

    sbd_up_e state_reg;
    sbd_up_e state_next;
    logic [`SBD_ADDR_W-1:0] up_addr_reg;
    logic [`SBD_ADDR_W-1:0] up_addr_next;
    sbd_pkg::sbd_cmd_e up_cmd_reg;
    sbd_pkg::sbd_cmd_e up_cmd_next;
    logic flush_after_reg;
    logic flush_after_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic claim_valid_reg;
    logic claim_valid_next;
    logic [`SBD_ADDR_W-1:0] claim_addr_reg;
    logic [`SBD_ADDR_W-1:0] claim_addr_next;
    sbd_pkg::sbd_cmd_e claim_cmd_reg;
    sbd_pkg::sbd_cmd_e claim_cmd_next;
    logic in_win;
    logic sec_in_win;
    logic cfg_hit;
    logic claim;
    logic forward;
    logic issue_flush;
    logic sec_take;
    logic cnt_full;
    logic vis_n_reg;
    logic vis_n_next;

    ////////////////////////////////////////////////////////////////////////
    // Primary-side claim decision
    // The window is both the bridge header range and the own positive decode
    assign in_win = link.dn_addr >= WIN_BASE && link.dn_addr <= WIN_LIMIT;
    // Config cycles to bus 0 reach the function-header bridge
    assign cfg_hit = link.dn_cmd == sbd_pkg::SBD_CMD_CONFIG &&
        (!FUNC_HEADER || link.dn_bus == `SBD_CFG_BUS0); // see RULE13
    // Flag alone claims; node tag not consulted, so zero tags work
    assign claim = link.dn_legacy_route || CHAIN_END || in_win || cfg_hit; // see RULE6, see RULE7, see RULE8, see RULE10
    // Unclaimed requests pass on down the chain; accept them too
    assign link.dn_ready = 1'b1;

    // Claimed request registered toward the legacy bus
    // Command and address stay after the pulse, so a slow legacy side may read them late
    always_comb begin
        claim_valid_next = link.dn_valid && claim;
        claim_addr_next = claim_addr_reg;
        claim_cmd_next = claim_cmd_reg;
        if (claim_valid_next) begin
            claim_addr_next = link.dn_addr;
            claim_cmd_next = link.dn_cmd;
        end
    end

    // Registers only; every choice is made in the process above
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            claim_valid_reg <= 1'b0;
            claim_addr_reg <= '0;
            claim_cmd_reg <= sbd_pkg::SBD_CMD_NP_READ;
        end else begin
            claim_valid_reg <= claim_valid_next;
            claim_addr_reg <= claim_addr_next;
            claim_cmd_reg <= claim_cmd_next;
        end
    end
    assign CLAIM_VALID = claim_valid_reg;
    assign CLAIM_ADDR = claim_addr_reg;
    assign CLAIM_CMD = claim_cmd_reg;

    ////////////////////////////////////////////////////////////////////////
    // Secondary-side forwarding
    assign sec_in_win = SEC_ADDR >= WIN_BASE && SEC_ADDR <= WIN_LIMIT;
    // Function header claims everything; bridge header only misses
    assign forward = FUNC_HEADER || !sec_in_win; // see RULE11, see RULE12
    // The secondary side stalls while a request or its flush is still queued
    assign SEC_READY = state_reg == SBD_UP_IDLE;
    assign sec_take = SEC_VALID && SEC_READY;
    assign SEC_LOCAL = sec_take && !forward;
    // A flush waits while the count is full: a wrap to zero would fake visibility
    assign cnt_full = cnt_reg == {CNT_W{1'b1}};
    assign link.up_valid = state_reg == SBD_UP_REQ || (state_reg == SBD_UP_FLUSH && !cnt_full);
    assign link.up_cmd = up_cmd_reg;
    assign link.up_addr = up_addr_reg;
    assign issue_flush = state_reg == SBD_UP_FLUSH && !cnt_full && link.up_ready;

    // Upstream sender; a legacy posted write is chased by a flush
    always_comb begin
        state_next = state_reg;
        up_addr_next = up_addr_reg;
        up_cmd_next = up_cmd_reg;
        flush_after_next = flush_after_reg;
        unique case (state_reg)
            SBD_UP_IDLE: begin
                // Only posted writes from the legacy side are chased by a flush
                if (sec_take && forward) begin
                    state_next = SBD_UP_REQ;
                    up_addr_next = SEC_ADDR;
                    up_cmd_next = SEC_CMD;
                    flush_after_next = SEC_FROM_LEGACY && SEC_CMD == sbd_pkg::SBD_CMD_POSTED_WRITE; // see RULE1
                end
            end
            SBD_UP_REQ: begin
                if (link.up_ready) begin
                    state_next = flush_after_reg ? SBD_UP_FLUSH : SBD_UP_IDLE;
                    // The flush reuses the captured address; only the command changes
                    up_cmd_next = sbd_pkg::SBD_CMD_FLUSH;
                end
            end
            SBD_UP_FLUSH: begin
                // Only a flush that the host really took counts as issued
                if (issue_flush) begin
                    state_next = SBD_UP_IDLE;
                    flush_after_next = 1'b0;
                end
            end
            default: begin
                // Unused code falls back to idle
                state_next = SBD_UP_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Flush bookkeeping behind the visibility pin

    // Outstanding count; issue and answer together leave it unchanged
    // An answer with nothing outstanding is ignored rather than wrapping below zero
    always_comb begin
        cnt_next = cnt_reg;
        if (issue_flush && !link.flush_done) begin
            cnt_next = cnt_reg + 1'b1; // see RULE14
        end else if (!issue_flush && link.flush_done && cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1; // see RULE14
        end
        vis_n_next = cnt_next != '0; // see RULE3
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= SBD_UP_IDLE;
            up_addr_reg <= '0;
            up_cmd_reg <= sbd_pkg::SBD_CMD_NP_READ;
            flush_after_reg <= 1'b0;
            cnt_reg <= '0;
            vis_n_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            up_addr_reg <= up_addr_next;
            up_cmd_reg <= up_cmd_next;
            flush_after_reg <= flush_after_next;
            cnt_reg <= cnt_next;
            vis_n_reg <= vis_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Visibility pin, from a flop so it cannot glitch while the count changes
    // Low (asserted) only when nothing is outstanding
    assign POSTED_WRITE_VISIBLE_N = vis_n_reg; // see RULE3
endmodule

//--- sbd_link_asserts.sv
// Concurrent checks on the host to bridge link
`timescale 1ns/1ps
`include "sbd_defines.svh"
module sbd_link_asserts (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link signals
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire logic [`SBD_TAG_W-1:0] dn_node_tag,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire sbd_pkg::sbd_cmd_e up_cmd,
    input wire logic [`SBD_ADDR_W-1:0] up_addr,
    input wire logic flush_done
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic pend_reg;
    logic pend_next;
    logic fl_go;
    ////////////////////////////////////////////////////////////////
    // Flush outstanding; issue wins, as the host allows only one at a time
    assign fl_go = up_valid && up_ready && (up_cmd == sbd_pkg::SBD_CMD_FLUSH);
    always_comb begin
        pend_next = fl_go ? 1'b1 : (flush_done ? 1'b0 : pend_reg);
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_ready_high; dn_ready; endproperty
    a_ready_high: assert property (p_ready_high) else $error("bridge refused a request");
    property p_node_tag; dn_valid |-> dn_node_tag == '0; endproperty
    a_node_tag: assert property (p_node_tag) else $error("node tag not zero");
    property p_up_hold; up_valid && !up_ready |=> up_valid && $stable(up_cmd) && $stable(up_addr); endproperty
    a_up_hold: assert property (p_up_hold) else $error("upstream request dropped");
    property p_flush_pulse; flush_done |=> !flush_done; endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("flush answer too long");
    property p_flush_cause; flush_done |-> pend_reg; endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("flush answer unasked");
    // The host reopens in the cycle in which its answer stands
    property p_one_flush; pend_reg && !flush_done |-> !up_ready; endproperty
    a_one_flush: assert property (p_one_flush) else $error("taken while flush pending");
    property p_not_same; fl_go |-> !flush_done; endproperty
    a_not_same: assert property (p_not_same) else $error("flush answered at issue");
    property p_no_cfg; up_valid |-> up_cmd != sbd_pkg::SBD_CMD_CONFIG; endproperty
    a_no_cfg: assert property (p_no_cfg) else $error("config sent upstream");
endmodule

//--- subtractive_bridge_decode_tb.sv
// Self-checking bench for both ends of the subtractive bridge link
`timescale 1ns/1ps
`include "sbd_defines.svh"
module subtractive_bridge_decode_tb;
    logic CLK, RST_N, REQ_VALID, REQ_READY, REQ_OTHER_CHAIN, WRITES_VISIBLE, UP_SEEN;
    logic CHAIN_END, FUNC_HEADER, CLAIM_VALID, SEC_VALID, SEC_READY, SEC_FROM_LEGACY, SEC_LOCAL;
    logic POSTED_WRITE_VISIBLE_N;
    logic [63:0] RANGE_BASE, RANGE_LIMIT;
    logic [1:0] RANGE_ON_COMPAT;
    logic [7:0] REQ_BUS;
    logic [31:0] REQ_ADDR, SEC_ADDR, UP_ADDR_OUT, CLAIM_ADDR, a;
    sbd_pkg::sbd_cmd_e REQ_CMD, SEC_CMD, CLAIM_CMD, c;
    int err_total, samples_checked;
    logic [33:0] claim_q[$];
    logic [31:0] seen_q[$];
    logic [33:0] up_q[$];
    sbd_link_if sbd_link_if_inst ();
    sbd_host sbd_host_inst (.CLK, .RST_N, .RANGE_BASE, .RANGE_LIMIT, .RANGE_ON_COMPAT, .REQ_VALID, .REQ_READY,
        .REQ_CMD, .REQ_ADDR, .REQ_BUS, .REQ_OTHER_CHAIN, .WRITES_VISIBLE, .UP_SEEN, .UP_ADDR_OUT,
        .link(sbd_link_if_inst));
    sbd_bridge sbd_bridge_inst (.CLK, .RST_N, .CHAIN_END, .FUNC_HEADER, .WIN_BASE(32'h0000_1000),
        .WIN_LIMIT(32'h0000_17FF), .CLAIM_VALID, .CLAIM_CMD, .CLAIM_ADDR, .SEC_VALID, .SEC_READY, .SEC_CMD,
        .SEC_ADDR, .SEC_FROM_LEGACY, .SEC_LOCAL, .POSTED_WRITE_VISIBLE_N, .link(sbd_link_if_inst));
    sbd_link_asserts sbd_link_asserts_inst (.CLK, .RST_N, .dn_valid(sbd_link_if_inst.dn_valid),
        .dn_ready(sbd_link_if_inst.dn_ready), .dn_node_tag(sbd_link_if_inst.dn_node_tag),
        .up_valid(sbd_link_if_inst.up_valid), .up_ready(sbd_link_if_inst.up_ready),
        .up_cmd(sbd_link_if_inst.up_cmd), .up_addr(sbd_link_if_inst.up_addr),
        .flush_done(sbd_link_if_inst.flush_done));
    ////////////////////////////////////////////////////////////////
    // Clock, and a watchdog far beyond the few hundred cycles the tests need
    initial begin
        CLK = 0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        #1_000_000;
        err_total++;
        final_report();
    end
    // Capture claims and upstream handshakes as the model's observed results
    always @(posedge CLK) begin
        if (CLAIM_VALID === 1'b1) claim_q.push_back({CLAIM_CMD, CLAIM_ADDR});
        if (UP_SEEN === 1'b1) seen_q.push_back(UP_ADDR_OUT);
        if (sbd_link_if_inst.up_valid === 1'b1 && sbd_link_if_inst.up_ready === 1'b1)
            up_q.push_back({sbd_link_if_inst.up_cmd, sbd_link_if_inst.up_addr});
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Processor request; inputs held until the host takes them
    task automatic req(input logic [7:0] bus, input logic ec, input logic eo);
        int n;
        @(negedge CLK);
        REQ_VALID = 1;
        REQ_CMD = c;
        REQ_ADDR = a;
        REQ_BUS = bus;
        #2;
        for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) begin
            @(negedge CLK);
            #2;
        end
        check(REQ_OTHER_CHAIN, eo);
        @(negedge CLK);
        REQ_VALID = 0;
        repeat (6) @(negedge CLK);
        check(claim_q.size(), ec);
        if (claim_q.size() > 0) check(claim_q.pop_front(), {c, a});
        claim_q.delete();
    endtask
    // Secondary request; a miss or function header goes upstream, legacy writes add a flush
    task automatic sec(input logic leg);
        int n;
        logic fwd;
        int n_up;
        fwd = FUNC_HEADER || !(a inside {[32'h0000_1000:32'h0000_17FF]});
        n_up = int'(fwd) + int'(fwd && leg && c == sbd_pkg::SBD_CMD_POSTED_WRITE);
        @(negedge CLK);
        SEC_VALID = 1;
        SEC_CMD = c;
        SEC_ADDR = a;
        SEC_FROM_LEGACY = leg;
        #2;
        for (n = 0; n < 40 && SEC_READY !== 1'b1; n++) begin
            @(negedge CLK);
            #2;
        end
        check(SEC_LOCAL, !fwd);
        @(negedge CLK);
        SEC_VALID = 0;
        repeat (8) @(negedge CLK);
        check(up_q.size(), n_up);
        check(seen_q.size(), n_up);
        if (fwd && seen_q.size() > 0) check(seen_q.pop_front(), a);
        seen_q.delete();
        if (fwd && up_q.size() > 0) check(up_q.pop_front(), {c, a});
        if (up_q.size() > 0) check(up_q.pop_front() >> 32, 34'(sbd_pkg::SBD_CMD_FLUSH));
        up_q.delete();
    endtask
    ////////////////////////////////////////////////////////////////
    // Ranges: compat chain 1000-1FFF, other chain 2000-2FFF, the rest misses
    initial begin
        {RST_N, REQ_VALID, SEC_VALID, SEC_FROM_LEGACY, CHAIN_END, FUNC_HEADER} = '0;
        {REQ_ADDR, SEC_ADDR, REQ_BUS, WRITES_VISIBLE} = '1;
        {REQ_CMD, SEC_CMD} = '0;
        RANGE_BASE = {32'h0000_2000, 32'h0000_1000};
        RANGE_LIMIT = {32'h0000_2FFF, 32'h0000_1FFF};
        RANGE_ON_COMPAT = 2'b01;
        void'($urandom(32'h5ED1));
        repeat (12) @(posedge CLK);
        check(POSTED_WRITE_VISIBLE_N, 1'b0);
        @(negedge CLK);
        RST_N = 1;
        // Every strap pairing against miss, window, compat-only, other chain and config cycles
        for (int s = 0; s < 4; s++) begin
            {CHAIN_END, FUNC_HEADER} = s[1:0];
            for (int k = 0; k < 6; k++) begin
                a = (k == 0) ? (32'h4000_0000 | ($urandom & 32'h0FFF_FFFF)) :
                    (k == 1) ? 32'h0000_1100 : (k == 3) ? 32'h0000_2100 : 32'h0000_1900;
                c = (k >= 4) ? sbd_pkg::SBD_CMD_CONFIG : (k == 1) ? sbd_pkg::SBD_CMD_POSTED_WRITE :
                    sbd_pkg::SBD_CMD_NP_READ;
                req((k == 5) ? 8'h03 : 8'h00, k != 3 && (k == 0 || k == 1 || CHAIN_END ||
                    (k == 4) || (k == 5 && !FUNC_HEADER)), k == 3);
            end
            // Upstream traffic with both header kinds
            for (int k = 0; k < 4; k++) begin
                a = k[1] ? 32'h0000_1100 : (32'h8000_0000 | ($urandom & 32'h0FFF_FFFF));
                c = k[0] ? sbd_pkg::SBD_CMD_POSTED_WRITE : sbd_pkg::SBD_CMD_NP_READ;
                sec(1'($urandom));
            end
        end
        // Hold visibility off: the pin must stay high until the flush is answered
        WRITES_VISIBLE = 0;
        a = 32'h9000_0000;
        c = sbd_pkg::SBD_CMD_POSTED_WRITE;
        sec(1'b1);
        check(POSTED_WRITE_VISIBLE_N, 1'b1);
        WRITES_VISIBLE = 1;
        repeat (5) @(negedge CLK);
        check(POSTED_WRITE_VISIBLE_N, 1'b0);
        final_report();
    end
endmodule
